// [src/tw_map.svh]
// Register map, field positions, reset values and timing figures of the two-wire master.
// Assumes a byte-addressed register port with 32-bit words on aligned offsets.
`ifndef TW_MAP_SVH
`define TW_MAP_SVH

// Register byte offsets.
`define TW_CTRL_OFS   8'h00
`define TW_MODE_OFS   8'h04
`define TW_SUBA_OFS   8'h0C
`define TW_CWG_OFS    8'h10
`define TW_STAT_OFS   8'h20
`define TW_IEN_OFS    8'h24
`define TW_IDIS_OFS   8'h28
`define TW_IMASK_OFS  8'h2C
`define TW_RXH_OFS    8'h30
`define TW_TXH_OFS    8'h34

// Command bits of the control register.
`define TW_CR_START   0
`define TW_CR_STOP    1
`define TW_CR_MON     2
`define TW_CR_MOFF    3
`define TW_CR_SRST    7

// Mode register fields and writable bits.
`define TW_MM_SZ_LSB  8
`define TW_MM_RD      12
`define TW_MM_DA_LSB  16
`define TW_MM_MASK    32'h007F_1300
`define TW_MM_RESET   32'h0000_0000

// Sub-address and clock waveform registers.
`define TW_SUBA_MASK  32'h00FF_FFFF
`define TW_SUBA_RESET 32'h0000_0000
`define TW_CW_LO_LSB  0
`define TW_CW_HI_LSB  8
`define TW_CW_PS_LSB  16
`define TW_CW_MASK    32'h0007_FFFF
`define TW_CW_RESET   32'h0000_0000

// Status flag positions, implemented flags and reset value.
`define TW_SR_TXC     0
`define TW_SR_RXR     1
`define TW_SR_TXR     2
`define TW_SR_OVR     6
`define TW_SR_UNR     7
`define TW_SR_NAK     8
`define TW_SR_MASK    9'h1C7
`define TW_SR_RESET   32'h0000_0008
`define TW_IM_RESET   9'h000
`define TW_HOLD_RESET 8'h00

// Fixed master clock periods added to every clock phase.
`define TW_CLK_EXTRA  16'h0003
// Bit index of the acknowledge slot within a byte.
`define TW_ACK_BIT    4'h8

`endif

// [src/tw_pkg.sv]
// Types shared by the two-wire master, its checker and its bench.
// Assumes the map header supplies all numeric constants.
package tw_pkg;

  // Serial sequencer states, one-hot.
  typedef enum logic [8:0] {
    TW_IDLE = 9'h001,
    TW_STA  = 9'h002,
    TW_BLO  = 9'h004,
    TW_BHI  = 9'h008,
    TW_RLO  = 9'h010,
    TW_RHI  = 9'h020,
    TW_PLO  = 9'h040,
    TW_PHI  = 9'h080,
    TW_PEND = 9'h100
  } tw_state_t;

  // Kind of byte currently in the shifter.
  typedef enum logic [1:0] {
    TW_K_ADDR = 2'h0,
    TW_K_SUB  = 2'h1,
    TW_K_DATA = 2'h2
  } tw_kind_t;

  // Register port request from software.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tw_bus_req_t;

  // Open-drain pad drive; an enable pulls the wire low.
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } tw_pad_out_t;

  // Pad levels as seen on the wires.
  typedef struct packed {
    logic scl_i;
    logic sda_i;
  } tw_pad_in_t;

endpackage

// [src/tw_phase_timer.sv]
// Phase timer that measures each low or high half of the serial clock.
// Assumes the caller clears it while idle and switches phase right on done.
`include "tw_map.svh"

module tw_phase_timer #(
  parameter int CW = 16
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Control.
  input  wire logic       clr,
  input  wire logic       sel_high,
  // Waveform settings.
  input  wire logic [7:0] low_div,
  input  wire logic [7:0] high_div,
  input  wire logic [2:0] prescale,
  // End of the current phase.
  output logic            done
);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] per;

  // Phase length is divider shifted by the prescale plus three cycles.
  assign per  = (CW'(sel_high ? high_div : low_div) << prescale) + CW'(`TW_CLK_EXTRA);
  // Greater-or-equal keeps a mid-phase change of settings from wrapping the count.
  assign done = cnt_reg >= CW'(per - CW'(1));

  // The count restarts at every phase boundary so each phase gets its full length.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (clr || done) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= CW'(cnt_reg + CW'(1));
    end
  end

endmodule

// [src/tw_master.sv]
// Two-wire bus master with its software register bank.
// Assumes open-drain pads outside, pull-ups on both wires, one 40 MHz clock.
`include "tw_map.svh"

module tw_master (
  // Clock and reset.
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // Register port.
  input  tw_pkg::tw_bus_req_t bus_req,
  output logic [31:0]         reg_rdata,
  // Open-drain pads.
  input  tw_pkg::tw_pad_in_t  pad_in,
  output tw_pkg::tw_pad_out_t pad_out,
  // Interrupt.
  output logic                irq
);
  import tw_pkg::*;

  localparam logic [31:0] SR_RST  = `TW_SR_RESET;
  localparam logic [8:0]  SR_MASK = `TW_SR_MASK;

  // Address compare shared by the write and strobe decodes; the read data decode uses a case.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Sub-address byte n-1 of the register, so the top byte goes first.
  function automatic logic [7:0] sub_byte(input logic [23:0] v, input logic [1:0] n);
    case (n)
      2'h3:    return v[23:16];
      2'h2:    return v[15:8];
      default: return v[7:0];
    endcase
  endfunction

  logic        soft_rst_reg;
  logic        rst_int;
  logic [31:0] mode_reg;
  logic [31:0] sub_reg;
  logic [31:0] cwg_reg;
  logic [8:0]  mask_reg;
  logic [7:0]  thr_reg;
  logic        master_en_reg;
  logic        off_pend_reg;
  logic [8:0]  stat_reg;
  tw_state_t   state_reg;
  tw_kind_t    kind_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_reg;
  logic [1:0]  ia_left_reg;
  logic        rd_phase_reg;
  logic        restart_reg;
  logic        stop_req_reg;
  logic        nack_reg;
  logic        thr_valid_reg;
  logic [7:0]  rhr_reg;
  logic        ev_begin_reg;
  logic        ev_load_reg;
  logic        ev_rx_reg;
  logic        ev_underrun_flag_reg;
  logic        ev_done_reg;
  logic        scl_m;
  logic        scl_s;
  logic        sda_m;
  logic        sda_s;
  logic        ctrl_wr;
  logic        ien_wr;
  logic        idis_wr;
  logic        thr_wr;
  logic        stat_rd;
  logic        rhr_rd;
  logic        cmd_start;
  logic        cmd_stop;
  logic        cmd_on;
  logic        cmd_off;
  logic [6:0]  slave_address;
  logic        read_direction;
  logic [1:0]  sub_addr_size;
  logic [7:0]  low_divider;
  logic [7:0]  high_divider;
  logic [2:0]  clock_prescale;
  logic        idle;
  logic        direct_rd;
  logic        frame_go;
  logic        rxing;
  logic        sel_high;
  logic        tick;
  logic [7:0]  sub_next;

  // Register strobes; unmapped offsets decode to nothing.
  assign ctrl_wr = bus_req.wr && hit(bus_req.addr, `TW_CTRL_OFS);
  assign ien_wr  = bus_req.wr && hit(bus_req.addr, `TW_IEN_OFS);
  assign idis_wr = bus_req.wr && hit(bus_req.addr, `TW_IDIS_OFS);
  assign thr_wr  = bus_req.wr && hit(bus_req.addr, `TW_TXH_OFS);
  assign stat_rd = bus_req.rd && hit(bus_req.addr, `TW_STAT_OFS);
  assign rhr_rd  = bus_req.rd && hit(bus_req.addr, `TW_RXH_OFS);

  // Command bits act only when written as one.
  assign cmd_start = ctrl_wr && bus_req.wdata[`TW_CR_START];
  assign cmd_stop  = ctrl_wr && bus_req.wdata[`TW_CR_STOP];
  assign cmd_on    = ctrl_wr && bus_req.wdata[`TW_CR_MON] && !bus_req.wdata[`TW_CR_MOFF];
  assign cmd_off   = ctrl_wr && bus_req.wdata[`TW_CR_MOFF];

  // Fields of the mode and clock waveform registers.
  assign slave_address  = mode_reg[`TW_MM_DA_LSB +: 7];
  assign read_direction = mode_reg[`TW_MM_RD];
  assign sub_addr_size  = mode_reg[`TW_MM_SZ_LSB +: 2];
  assign low_divider    = cwg_reg[`TW_CW_LO_LSB +: 8];
  assign high_divider   = cwg_reg[`TW_CW_HI_LSB +: 8];
  assign clock_prescale = cwg_reg[`TW_CW_PS_LSB +: 3];

  // Frame launch and sequencer helpers.
  assign idle      = state_reg == TW_IDLE;
  assign direct_rd = read_direction && (sub_addr_size == 2'h0);
  assign frame_go  = idle && master_en_reg && !off_pend_reg &&
                     (cmd_start || (thr_wr && !read_direction));
  assign rxing     = rd_phase_reg && (kind_reg == TW_K_DATA);
  assign sel_high  = (state_reg == TW_STA) || (state_reg == TW_BHI) ||
                     (state_reg == TW_RHI) || (state_reg == TW_PHI) || (state_reg == TW_PEND);
  assign sub_next  = sub_byte(sub_reg[23:0], ia_left_reg);

  // The internal reset ORs the system reset with the soft reset flip-flop.
  assign rst_int = sys_rst | soft_rst_reg;

  // Soft reset pulse lasts one cycle; its flip-flop is reset by the system reset only.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= ctrl_wr && bus_req.wdata[`TW_CR_SRST];
    end
  end

  // Pad levels come from another domain and pass two flip-flops first.
  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_m <= pad_in.scl_i;
      scl_s <= scl_m;
      sda_m <= pad_in.sda_i;
      sda_s <= sda_m;
    end
  end

  // Software-written configuration, mask and master enable.
  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      mode_reg      <= `TW_MM_RESET;
      sub_reg       <= `TW_SUBA_RESET;
      cwg_reg       <= `TW_CW_RESET;
      mask_reg      <= `TW_IM_RESET;
      thr_reg       <= `TW_HOLD_RESET;
      master_en_reg <= 1'b0;
      off_pend_reg  <= 1'b0;
    end else begin
      if (bus_req.wr && hit(bus_req.addr, `TW_MODE_OFS)) begin
        mode_reg <= bus_req.wdata & `TW_MM_MASK;
      end
      if (bus_req.wr && hit(bus_req.addr, `TW_SUBA_OFS)) begin
        sub_reg <= bus_req.wdata & `TW_SUBA_MASK;
      end
      if (bus_req.wr && hit(bus_req.addr, `TW_CWG_OFS)) begin
        cwg_reg <= bus_req.wdata & `TW_CW_MASK;
      end
      if (thr_wr) begin
        thr_reg <= bus_req.wdata[7:0];
      end
      // Ones set or clear mask bits; zeros leave them alone.
      if (ien_wr) begin
        mask_reg <= mask_reg | (bus_req.wdata[8:0] & SR_MASK);
      end else if (idis_wr) begin
        mask_reg <= mask_reg & ~bus_req.wdata[8:0];
      end
      // Disabling waits for the sequencer to drain; no new frame starts meanwhile.
      if (off_pend_reg && idle) begin
        master_en_reg <= 1'b0;
        off_pend_reg  <= 1'b0;
      end
      if (cmd_off) begin
        off_pend_reg <= 1'b1;
      end else if (cmd_on) begin
        master_en_reg <= 1'b1;
        off_pend_reg  <= 1'b0;
      end
    end
  end

  // Phase timer: each clock half lasts the divider shifted by the prescale, plus three cycles.
  tw_phase_timer #(
    .CW(16)
  ) u_timer (
    .clk      (clk),
    .rst      (rst_int),
    .clr      (idle),
    .sel_high (sel_high),
    .low_div  (low_divider),
    .high_div (high_divider),
    .prescale (clock_prescale),
    .done     (tick)
  );

  // Serial sequencer: start, address, sub-address, data, acknowledge and stop.
  // SDA changes on the same edge that pulls SCL low; slaves rely on their own hold time.
  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      state_reg     <= TW_IDLE;
      pad_out       <= '0;
      shift_reg     <= 8'h00;
      bit_reg       <= 4'h0;
      kind_reg      <= TW_K_ADDR;
      ia_left_reg   <= 2'h0;
      rd_phase_reg  <= 1'b0;
      restart_reg   <= 1'b0;
      stop_req_reg  <= 1'b0;
      nack_reg      <= 1'b0;
      thr_valid_reg <= 1'b0;
      rhr_reg       <= `TW_HOLD_RESET;
      ev_begin_reg  <= 1'b0;
      ev_load_reg   <= 1'b0;
      ev_rx_reg     <= 1'b0;
      ev_underrun_flag_reg   <= 1'b0;
      ev_done_reg   <= 1'b0;
    end else begin
      ev_begin_reg <= 1'b0;
      ev_load_reg  <= 1'b0;
      ev_rx_reg    <= 1'b0;
      ev_underrun_flag_reg  <= 1'b0;
      ev_done_reg  <= 1'b0;
      if (cmd_stop) begin
        stop_req_reg <= 1'b1;
      end
      case (state_reg)
        TW_IDLE: begin
          // A stop that comes with the start makes a single-byte frame.
          stop_req_reg <= frame_go && cmd_stop;
          if (frame_go) begin
            state_reg      <= TW_STA;
            pad_out.sda_oe <= 1'b1; // Data falls while the clock is high.
            shift_reg      <= {slave_address, direct_rd};
            kind_reg       <= TW_K_ADDR;
            ia_left_reg    <= sub_addr_size;
            rd_phase_reg   <= direct_rd;
            restart_reg    <= read_direction && !direct_rd;
            nack_reg       <= 1'b0;
            ev_begin_reg   <= 1'b1;
          end
        end
        TW_STA: if (tick) begin
          state_reg      <= TW_BLO;
          pad_out.scl_oe <= 1'b1;
          pad_out.sda_oe <= !shift_reg[7];
          bit_reg        <= 4'h0;
        end
        TW_BLO: if (tick) begin
          state_reg      <= TW_BHI;
          pad_out.scl_oe <= 1'b0;
        end
        TW_BHI: if (tick) begin
          // Data is sampled at the end of the high phase, most significant first.
          shift_reg <= {shift_reg[6:0], sda_s};
          pad_out.scl_oe <= 1'b1;
          if (bit_reg != `TW_ACK_BIT) begin
            bit_reg   <= bit_reg + 4'h1;
            state_reg <= TW_BLO;
            if (bit_reg == 4'h7) begin
              // Receiving: acknowledge unless stop is due. Sending: release.
              pad_out.sda_oe <= rxing && !stop_req_reg;
              if (rxing) begin
                rhr_reg   <= {shift_reg[6:0], sda_s};
                ev_rx_reg <= 1'b1;
              end
            end else begin
              pad_out.sda_oe <= !rxing && !shift_reg[6];
            end
          end else begin
            bit_reg <= 4'h0;
            if (sda_s && !rxing) begin
              // A high line in the acknowledge slot ends the frame.
              nack_reg       <= 1'b1;
              state_reg      <= TW_PLO;
              pad_out.sda_oe <= 1'b1;
            end else if (ia_left_reg != 2'h0) begin
              shift_reg      <= sub_next;
              ia_left_reg    <= ia_left_reg - 2'h1;
              kind_reg       <= TW_K_SUB;
              state_reg      <= TW_BLO;
              pad_out.sda_oe <= !sub_next[7];
            end else if (restart_reg) begin
              // Reads with a sub-address turn round by a repeated start.
              restart_reg    <= 1'b0;
              rd_phase_reg   <= 1'b1;
              kind_reg       <= TW_K_ADDR;
              shift_reg      <= {slave_address, 1'b1};
              state_reg      <= TW_RLO;
              pad_out.sda_oe <= 1'b0;
            end else if ((kind_reg == TW_K_DATA) && stop_req_reg) begin
              state_reg      <= TW_PLO;
              pad_out.sda_oe <= 1'b1;
            end else if (rd_phase_reg) begin
              kind_reg       <= TW_K_DATA;
              state_reg      <= TW_BLO;
              pad_out.sda_oe <= 1'b0;
            end else if (thr_valid_reg) begin
              shift_reg      <= thr_reg;
              thr_valid_reg  <= 1'b0;
              ev_load_reg    <= 1'b1;
              kind_reg       <= TW_K_DATA;
              state_reg      <= TW_BLO;
              pad_out.sda_oe <= !thr_reg[7];
            end else begin
              // Nothing left to send: flag underrun and stop.
              ev_underrun_flag_reg    <= 1'b1;
              state_reg      <= TW_PLO;
              pad_out.sda_oe <= 1'b1;
            end
          end
        end
        TW_RLO: if (tick) begin
          state_reg      <= TW_RHI;
          pad_out.scl_oe <= 1'b0;
        end
        TW_RHI: if (tick) begin
          state_reg      <= TW_STA;
          pad_out.sda_oe <= 1'b1;
        end
        TW_PLO: if (tick) begin
          state_reg      <= TW_PHI;
          pad_out.scl_oe <= 1'b0;
        end
        TW_PHI: if (tick) begin
          state_reg      <= TW_PEND; // Data rises while the clock is high.
          pad_out.sda_oe <= 1'b0;
        end
        TW_PEND: if (tick) begin
          // The bus-free time after stop keeps back-to-back frames legal.
          state_reg    <= TW_IDLE;
          stop_req_reg <= 1'b0;
          ev_done_reg  <= 1'b1;
        end
        default: begin
          state_reg      <= TW_IDLE;
          pad_out.scl_oe <= 1'b0;
          pad_out.sda_oe <= 1'b0;
        end
      endcase
      // A write in the same cycle as a load keeps the new byte pending.
      if (thr_wr) begin
        thr_valid_reg <= 1'b1;
      end
    end
  end

  // Status flags: clears first, then sets, so a coinciding event is kept.
  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      stat_reg <= SR_RST[8:0] & SR_MASK;
    end else begin
      if (stat_rd) begin
        stat_reg[`TW_SR_NAK] <= 1'b0;
        if (stat_reg[`TW_SR_TXC]) begin
          stat_reg[`TW_SR_OVR] <= 1'b0;
          stat_reg[`TW_SR_UNR] <= 1'b0;
        end
      end
      if (rhr_rd) begin
        stat_reg[`TW_SR_RXR] <= 1'b0;
      end
      if (thr_wr) begin
        stat_reg[`TW_SR_TXR] <= 1'b0;
      end
      if (ev_begin_reg) begin
        stat_reg[`TW_SR_TXC] <= 1'b0;
      end
      if (ev_rx_reg) begin
        stat_reg[`TW_SR_RXR] <= 1'b1;
        if (stat_reg[`TW_SR_RXR] && !rhr_rd) begin
          stat_reg[`TW_SR_OVR] <= 1'b1;
        end
      end
      if (ev_load_reg) begin
        stat_reg[`TW_SR_TXR] <= 1'b1;
      end
      if (ev_underrun_flag_reg) begin
        stat_reg[`TW_SR_UNR] <= 1'b1;
      end
      if (ev_done_reg) begin
        stat_reg[`TW_SR_TXC] <= 1'b1;
        if (nack_reg) begin
          stat_reg[`TW_SR_NAK] <= 1'b1;
          stat_reg[`TW_SR_TXR] <= 1'b1;
        end
      end
      if (cmd_on) begin
        stat_reg[`TW_SR_TXC] <= 1'b1;
        stat_reg[`TW_SR_TXR] <= 1'b1;
      end
    end
  end

  // Read data stand in the cycle after the read strobe; unmapped offsets read zero.
  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (bus_req.rd) begin
        case (bus_req.addr)
          `TW_MODE_OFS:  reg_rdata <= mode_reg;
          `TW_SUBA_OFS:  reg_rdata <= sub_reg;
          `TW_CWG_OFS:   reg_rdata <= cwg_reg;
          `TW_STAT_OFS:  reg_rdata <= {23'h000000, stat_reg & SR_MASK} |
                                      (SR_RST & ~{23'h000000, SR_MASK});
          `TW_IMASK_OFS: reg_rdata <= {23'h000000, mask_reg};
          `TW_RXH_OFS:   reg_rdata <= {24'h000000, rhr_reg};
          `TW_TXH_OFS:   reg_rdata <= {24'h000000, thr_reg};
          default:       reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Interrupt is a level, one cycle behind the flags and mask.
  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_reg & mask_reg & SR_MASK);
    end
  end

endmodule

// [dv/tw_master_chk.sv]
// Port checker for the two-wire master, bound onto its top module.
// Assumes the waveform register stays zero, so every clock phase is 3 cycles.
module tw_master_chk (
  // Clock and reset.
  input wire logic          clk,
  input wire logic          sys_rst,
  // Register port, pads and interrupt.
  input tw_pkg::tw_bus_req_t bus_req,
  input wire logic [31:0]   reg_rdata,
  input tw_pkg::tw_pad_in_t  pad_in,
  input tw_pkg::tw_pad_out_t pad_out,
  input wire logic          irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import tw_pkg::*;
  logic [8:0] mask_q;
  logic       en_q;
  logic       srst_q;

  // Mirror of mask and enable; soft reset lands a cycle late, so it never claims too early.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_q <= 9'h000;
      en_q   <= 1'b0;
      srst_q <= 1'b0;
    end else begin
      srst_q <= bus_req.wr && bus_req.addr == 8'h00 && bus_req.wdata[7];
      if (srst_q) begin
        mask_q <= 9'h000;
        en_q   <= 1'b0;
      end else if (bus_req.wr && bus_req.addr == 8'h24) begin
        mask_q <= mask_q | (bus_req.wdata[8:0] & 9'h1C7);
      end else if (bus_req.wr && bus_req.addr == 8'h28) begin
        mask_q <= mask_q & ~bus_req.wdata[8:0];
      end else if (bus_req.wr && bus_req.addr == 8'h00 && bus_req.wdata[3:2] == 2'h1) begin
        en_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence start_seen_s; $rose(pad_out.sda_oe) && !pad_out.scl_oe; endsequence
  sequence start_hold_s; !pad_out.scl_oe [*3] ##1 pad_out.scl_oe; endsequence

  start_len_a: assert property (start_seen_s |-> start_hold_s)
    else $error("start phase length wrong");
  low_len_a: assert property ($rose(pad_out.scl_oe) |-> pad_out.scl_oe [*3] ##1 !pad_out.scl_oe)
    else $error("clock low phase length wrong");
  high_len_a: assert property ($fell(pad_out.scl_oe) |-> !pad_out.scl_oe [*3])
    else $error("clock high phase too short");
  stop_idle_a: assert property ($fell(pad_out.sda_oe) && !pad_out.scl_oe |-> !pad_out.sda_oe [*3])
    else $error("stop not followed by idle bus");
  idle_off_a: assert property (!en_q |-> !pad_out.sda_oe && !pad_out.scl_oe)
    else $error("pads driven while disabled");
  pad_zero_a: assert property (!pad_out.scl_o && !pad_out.sda_o)
    else $error("open-drain data level not zero");
  irq_mask_a: assert property (mask_q == 9'h000 |=> !irq)
    else $error("interrupt with empty mask");
  mask_view_a: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 8'h2C
    |-> reg_rdata == {23'h0, mask_q})
    else $error("mask view wrong");
  rdata_idle_a: assert property (!$past(bus_req.rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
endmodule

bind tw_master tw_master_chk tw_master_chk_inst (.clk(clk), .sys_rst(sys_rst),
  .bus_req(bus_req), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .irq(irq));

// [dv/tw_slave_model.sv]
// Behavioural slave device on the two-wire bus.
// Assumes resolved wire levels; it only ever pulls the data line low.
module tw_slave_model #(
  parameter logic [7:0] RD_BYTE = 8'h96
) (
  // Wire levels and fault control.
  input  wire logic   scl,
  input  wire logic   sda,
  input  wire logic   nak,
  // Data pull-down and log of acknowledged bytes.
  output logic        sda_oe,
  output logic [31:0] log_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sr;
  int         bc;
  logic       first;
  logic       rd;

  initial begin
    sda_oe = 1'b0;
    log_q = 32'h0;
    bc = 0;
    first = 1'b0;
    rd = 1'b0;
  end

  // Data falling with the clock high opens a frame; the delay skips same-step bit changes.
  always @(negedge sda) begin
    #1;
    if (scl) begin
      bc = 0;
      first = 1'b1;
      rd = 1'b0;
    end
  end

  // Bits taken on the rising clock, most significant first; a released ninth bit ends a read.
  always @(posedge scl) begin
    if (bc == 8 && sda) rd = 1'b0;
    if (bc < 8) sr = {sr[6:0], sda};
    bc = bc + 1;
  end

  // Drive changes only on the falling clock: acknowledge written bytes, send read data.
  always @(negedge scl) begin
    sda_oe = 1'b0;
    if (bc == 8) begin
      if (first) rd = sr[0];
      if (first || (!rd && !nak)) begin
        sda_oe = 1'b1;
        log_q = {log_q[23:0], sr};
      end
      first = 1'b0;
    end else if (bc == 9) begin
      bc = 0;
    end
    if (rd && !first && bc < 8) sda_oe = !RD_BYTE[7 - bc];
  end
endmodule

// [dv/tb_tw_master.sv]
// Bench for the two-wire master: register stimulus and a slave on the wires.
// Assumes pull-ups on both wires, resolved here from every open-drain enable.
module tb_tw_master;
  timeunit 1ns;
  timeprecision 1ps;
  import tw_pkg::*;
  logic        clk, sys_rst, nak, s_oe, irq;
  tw_bus_req_t bus_req;
  tw_pad_in_t  pad_in;
  tw_pad_out_t pad_out;
  logic [31:0] reg_rdata, last_st, s_log;
  int          fails, check_count;

  // Each wire is high unless some party pulls it low.
  assign pad_in = {!pad_out.scl_oe, !(pad_out.sda_oe || s_oe)};
  tw_master tw_master_inst (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .irq(irq));
  tw_slave_model tw_slave_model_inst (.scl(pad_in.scl_i), .sda(pad_in.sda_i), .nak(nak),
    .sda_oe(s_oe), .log_q(s_log));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register cycles; a quiet cycle follows so a strobe is never set twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Polling reads also clear flags, so the completing status is kept in last_st.
  task automatic wait_done();
    repeat (4) @(posedge clk);
    for (int i = 0; i < 400; i++) begin
      rd(8'h20, last_st);
      if (last_st[0] === 1'b1) return;
    end
    fails++;
    close_out();
  endtask

  task automatic t_regs();
    logic [7:0]  a [8] = '{8'h04, 8'h0C, 8'h10, 8'h20, 8'h2C, 8'h30, 8'h34, 8'h08};
    logic [31:0] e [8] = '{32'h0, 32'h0, 32'h0, 32'h8, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++) begin
      rchk(a[i], e[i]);
    end
    $display("regs done");
  endtask

  task automatic t_mask();
    wr(8'h24, 32'h1FF);
    rchk(8'h2C, 32'h1C7);
    // Leave the transmit-ready source enabled so the interrupt below has a cause.
    wr(8'h28, 32'h3);
    rchk(8'h2C, 32'h1C4);
    wr(8'h00, 32'hC);
    rchk(8'h20, 32'h8);
    wr(8'h00, 32'h4);
    rchk(8'h20, 32'hD);
    chk(irq, 1'b1);
    wr(8'h28, 32'h1FF);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    $display("mask done");
  endtask

  task automatic t_write();
    wr(8'h04, 32'h0050_0200);
    wr(8'h0C, 32'h0012_3456);
    wr(8'h34, 32'hC3);
    wr(8'h00, 32'h2);
    wait_done();
    chk(s_log, 32'hA034_56C3);
    chk(last_st, 32'hD);
    wr(8'h04, 32'h0050_0000);
    wr(8'h34, 32'h5A);
    wait_done();
    chk(last_st, 32'h8D);
    chk(s_log & 32'hFFFF, 32'hA05A);
    rchk(8'h20, 32'hD);
    nak <= 1'b1;
    wr(8'h34, 32'h11);
    wr(8'h00, 32'h2);
    wait_done();
    chk(last_st, 32'h10D);
    rchk(8'h20, 32'hD);
    nak <= 1'b0;
    $display("write done");
  endtask

  task automatic t_read();
    wr(8'h04, 32'h0050_1000);
    wr(8'h00, 32'h3);
    wait_done();
    chk(last_st, 32'hF);
    chk(s_log & 32'hFF, 32'hA1);
    wr(8'h00, 32'h3);
    wait_done();
    chk(last_st, 32'h4F);
    rchk(8'h30, 32'h96);
    rchk(8'h20, 32'hD);
    wr(8'h24, 32'h1);
    @(posedge clk);
    chk(irq, 1'b1);
    wr(8'h00, 32'h80);
    t_regs();
    chk(irq, 1'b0);
    $display("read and reset done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    bus_req = '0;
    nak = 1'b0;
    sys_rst = 1'b1;
    fails = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_mask();
    t_write();
    t_read();
    close_out();
  end
endmodule
